// ### lpu_channel.sv
// One link channel of the protocol processing unit with its host register port.
// Assumes the link partner changes token bits away from the rising link clock edge.
//
// Contract
// - After reset the channel is transparent: no interpretation, no acknowledges.
// - EOP1 and EOP2 end received packets; transmit appends configured EOP marker.
// - Mode is set per channel by host port or by link writes.
// - Protocol mode takes four data tokens after EOP as header bytes.
// - Protocol mode acknowledges each packet with an accepted header only if auto-ack configured; with the queue full the acknowledge is dropped.
// - Acknowledges wait in their own queue until the transmit path is free.
// - Eight-bit routing addresses exist for three links and the device.
// - Routing mode takes first byte as destination and strips it.
// - Match of another link forwards there; own match goes to receive buffer.
// - No match still delivers locally and raises a maskable error.
// - Protocol data reaches receive buffer only with matching address and valid command.
// - Control commands in the header become execution requests.
// - Header bytes feed the acknowledge path; bad address, command or lock is error.
// - No header interpretation in transparent or routing mode.
// - Commands drive processor reset, external signals, one-link or all-link reset.
// - Safety-critical enable sets on request, clears after any safety command runs.
// - Optional packet checksum generation and checking, enabled by configuration.
// - Strap low selects little endian, high selects big endian.
// - Little endian puts byte 0 on bits 7:0 upward; port starts 8-bit.
// - Big endian puts byte 0 on bits 31:24 downward.
// - Byte-wide registers read zero outside their byte lane (bits 31:8 little, 23:0 big endian) for wider ports.
// - Decoded commands leave on five dedicated output lines.
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module lpu_channel #(
   parameter int CH_IDX    = 0,
   parameter int ACK_DEPTH = 4
) (
   input  wire logic                           clk_sys,
   input  wire logic                           rst,
   input  wire logic                           ce,
   input  wire logic [7:0]                     reg_addr,
   input  wire logic [31:0]                    reg_wdata,
   input  wire logic                           reg_we,
   input  wire logic                           reg_re,
   output logic      [31:0]                    reg_rdata,
   input  wire logic                           host_byte_order_strap,
   input  wire logic                           cfg_link_we,
   input  wire logic [7:0]                     cfg_link_wdata,
   input  wire logic                           lnk_clk,
   input  wire logic [lpu_pkg::TOK_W-1:0]      lnk_tok,
   output logic                                rx_valid,
   output logic      [7:0]                     rx_data,
   output logic                                rx_eop,
   output logic                                fwd_valid,
   output logic      [1:0]                     fwd_link,
   output logic      [7:0]                     fwd_data,
   output logic                                fwd_eop,
   input  wire logic                           mem_valid,
   input  wire logic [7:0]                     mem_data,
   input  wire logic                           mem_last,
   output logic                                mem_ready,
   output logic                                tx_tok_valid,
   output logic      [lpu_pkg::TOK_W-1:0]      tx_tok,
   input  wire logic                           tx_tok_ready,
   output logic      [lpu_pkg::CMD_LINES-1:0]  cmd_lines,
   output logic                                link_reset,
   output logic                                all_reset,
   output logic                                err_irq
);
   import lpu_pkg::*;

   typedef enum logic [3:0] {
      R_FIRST = 4'h1, R_HDR = 4'h2, R_DATA = 4'h4, R_DROP = 4'h8
   } lpu_rx_st_t;
   typedef enum logic [5:0] {
      T_IDLE = 6'h01, T_DATA = 6'h02, T_CHK = 6'h04,
      T_EOP  = 6'h08, T_ACK  = 6'h10, T_ACKE = 6'h20
   } lpu_tx_st_t;
   localparam int AW = $clog2(ACK_DEPTH);

   ////////////////////////////////////////////////////////////////////////////
   // Link pins and strap pass the three-stage synchroniser.
   logic [TOK_W+1:0] sync_lvl;
   logic             lclk_d;
   logic             big_end;
   lpu_pin_sync #(.W(TOK_W + 2)) u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ce      (ce),
      .pin_in  ({host_byte_order_strap, lnk_clk, lnk_tok}),
      .pin_lvl (sync_lvl)
   );
   wire             lclk_lvl = sync_lvl[TOK_W];
   wire [TOK_W-1:0] tok      = sync_lvl[TOK_W-1:0];
   wire             tok_stb  = lclk_lvl & ~lclk_d;
   wire [7:0]       tok_byte = tok[7:0];
   wire             tok_eop  = tok[TOK_CTL] & (tok_byte == CTL_EOP1 || tok_byte == CTL_EOP2);
   wire             d_stb    = tok_stb & ~tok[TOK_CTL];
   wire             e_stb    = tok_stb & tok_eop;

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers.
   logic [7:0] cfg_mode;
   logic [7:0] ch_addr;
   logic [7:0] rt_self;
   logic [7:0] rt_link [0:NUM_LINKS-1];
   logic [2:0] stat;
   logic [7:0] mask;
   logic [7:0] hdr [0:HDR_LEN-2];
   logic [15:0] pkt_cnt;
   logic        sc_en;

   wire [1:0] mode     = cfg_mode[M_MODE_LSB +: 2];
   wire       auto_ack = cfg_mode[M_AUTOACK];
   wire       chk_en   = cfg_mode[M_CHK];
   wire [1:0] wid      = cfg_mode[M_WID_LSB +: 2];
   wire [7:0] wbyte    = big_end ? reg_wdata[31:24] : reg_wdata[7:0];
   wire       wr_rtl   = reg_we && reg_addr >= A_RTL0 && reg_addr <= A_RTL2;
   wire [1:0] rtl_idx  = 2'(reg_addr - A_RTL0);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cfg_mode <= MODE_RST;
         ch_addr  <= ADDR_RST;
         rt_self  <= ADDR_RST;
         mask     <= MASK_RST;
         for (int i = 0; i < NUM_LINKS; i++) rt_link[i] <= ADDR_RST;
      end else if (ce) begin
         if (reg_we && reg_addr == A_MODE) cfg_mode <= wbyte;
         else if (cfg_link_we) cfg_mode <= cfg_link_wdata;
         if (reg_we && reg_addr == A_CHADDR) ch_addr <= wbyte;
         if (reg_we && reg_addr == A_RTSELF) rt_self <= wbyte;
         if (wr_rtl) rt_link[rtl_idx] <= wbyte;
         if (reg_we && reg_addr == A_MASK) mask <= wbyte;
      end
   end

   // The strap is static; following its synchroniser lets it settle after reset
   // instead of catching the synchroniser's reset value.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         big_end <= 1'b0;
         lclk_d  <= 1'b0;
      end else if (ce) begin
         lclk_d  <= lclk_lvl;
         big_end <= sync_lvl[TOK_W+1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive path: header handling, routing and checksum.
   lpu_rx_st_t st_rx;
   logic [1:0] hdr_cnt;
   logic       to_fwd;
   logic [1:0] fwd_idx;
   logic       pkt_ok;
   logic [7:0] rx_csum;
   logic       hit_link;
   logic [1:0] hit_idx;

   always_comb begin
      hit_link = 1'b0;
      hit_idx  = 2'h0;
      for (int i = 0; i < NUM_LINKS; i++) begin
         if (i != CH_IDX && !hit_link && tok_byte == rt_link[i]) begin
            hit_link = 1'b1;
            hit_idx  = 2'(i);
         end
      end
   end

   wire hit_self  = tok_byte == rt_self;
   wire route_1st = d_stb && st_rx == R_FIRST && mode == MODE_ROUTE;
   wire route_err = route_1st && !hit_self && !hit_link;
   wire hdr_last  = d_stb && st_rx == R_HDR && hdr_cnt == 2'(HDR_LEN - 1);
   wire [7:0] cmd = hdr[1];
   wire cmd_ctl   = cmd >= CMD_CPU_RST_ON && cmd <= CMD_SC_ENABLE;
   wire cmd_sc    = cmd == CMD_CPU_RST_ON || cmd == CMD_ALL_RST;
   wire sc_block  = cmd_sc && !sc_en;
   wire hdr_good  = hdr[0] == ch_addr && (cmd == CMD_DATA || cmd_ctl) && !sc_block;
   wire proto     = mode == MODE_PROTO;
   wire exec_go   = hdr_last && proto && hdr_good && cmd_ctl;
   wire hdr_err   = hdr_last && proto && !hdr_good;
   wire emit_d    = d_stb && (st_rx == R_DATA || (st_rx == R_FIRST && mode == MODE_TRANSP));
   wire emit_e    = e_stb && st_rx == R_DATA;
   wire ck_err    = emit_e && chk_en && rx_csum != 8'h00;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_rx   <= R_FIRST;
         hdr_cnt <= 2'h0;
         to_fwd  <= 1'b0;
         fwd_idx <= 2'h0;
         pkt_ok  <= 1'b0;
         rx_csum <= 8'h00;
         for (int i = 0; i < HDR_LEN - 1; i++) hdr[i] <= 8'h00;
      end else if (ce) begin
         if (emit_d) rx_csum <= rx_csum ^ tok_byte;
         if (e_stb) begin
            st_rx   <= R_FIRST;
            hdr_cnt <= 2'h0;
            to_fwd  <= 1'b0;
            rx_csum <= 8'h00;
         end else if (d_stb) begin
            unique case (st_rx)
               R_FIRST: begin
                  pkt_ok <= 1'b0;
                  if (mode == MODE_PROTO) begin
                     hdr[0]  <= tok_byte;
                     hdr_cnt <= 2'h1;
                     st_rx   <= R_HDR;
                  end else begin
                     to_fwd  <= route_1st && !hit_self && hit_link;
                     fwd_idx <= hit_idx;
                     st_rx   <= R_DATA;
                  end
               end
               R_HDR: begin
                  if (hdr_last) begin
                     pkt_ok <= hdr_good;
                     st_rx  <= (hdr_good && cmd == CMD_DATA) ? R_DATA : R_DROP;
                  end else begin
                     hdr[hdr_cnt] <= tok_byte;
                     hdr_cnt      <= hdr_cnt + 2'h1;
                  end
               end
               R_DATA:  st_rx <= R_DATA;
               R_DROP:  st_rx <= R_DROP;
            endcase
         end
      end
   end

   // Delivery to the local receive buffer or to another link.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_valid  <= 1'b0;
         rx_data   <= 8'h00;
         rx_eop    <= 1'b0;
         fwd_valid <= 1'b0;
         fwd_link  <= 2'h0;
         fwd_data  <= 8'h00;
         fwd_eop   <= 1'b0;
         pkt_cnt   <= 16'h0000;
      end else if (ce) begin
         rx_valid  <= (emit_d || emit_e) && !to_fwd;
         fwd_valid <= (emit_d || emit_e) && to_fwd;
         rx_data   <= emit_d ? tok_byte : 8'h00;
         fwd_data  <= emit_d ? tok_byte : 8'h00;
         rx_eop    <= emit_e && !to_fwd;
         fwd_eop   <= emit_e && to_fwd;
         fwd_link  <= fwd_idx;
         if (emit_e && !to_fwd) pkt_cnt <= pkt_cnt + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command execution and status. A flag set by hardware wins over a clear.
   wire [2:0] stat_set = {ck_err, hdr_err, route_err};
   wire [2:0] stat_clr = (reg_we && reg_addr == A_STAT) ? wbyte[2:0] : 3'h0;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cmd_lines  <= '0;
         link_reset <= 1'b0;
         all_reset  <= 1'b0;
         sc_en      <= 1'b0;
         stat       <= 3'h0;
         err_irq    <= 1'b0;
      end else if (ce) begin
         stat       <= (stat & ~stat_clr) | stat_set;
         err_irq    <= |(stat & mask[2:0]);
         link_reset <= exec_go && cmd == CMD_LINK_RST;
         all_reset  <= exec_go && cmd == CMD_ALL_RST;
         if (exec_go) begin
            unique case (cmd)
               CMD_CPU_RST_ON:  cmd_lines[0] <= 1'b1;
               CMD_CPU_RST_OFF: cmd_lines[0] <= 1'b0;
               CMD_SIG_SET:     cmd_lines[4:1] <= cmd_lines[4:1] | tok_byte[3:0];
               CMD_SIG_CLR:     cmd_lines[4:1] <= cmd_lines[4:1] & ~tok_byte[3:0];
               default:         cmd_lines <= cmd_lines;
            endcase
            if (cmd == CMD_SC_ENABLE) sc_en <= 1'b1;
            else if (cmd_sc) sc_en <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Acknowledge queue; the depth must be a power of two.
   logic [7:0]  ack_mem [0:ACK_DEPTH-1];
   logic [AW-1:0] ack_wp;
   logic [AW-1:0] ack_rp;
   logic [AW:0]   ack_n;
   lpu_tx_st_t  st_tx;
   wire tx_free  = !tx_tok_valid || tx_tok_ready;
   wire ack_full = ack_n == (AW+1)'(ACK_DEPTH);
   // Control packets end in the drop state and are acknowledged as well.
   wire pkt_end  = e_stb && st_rx inside {R_DATA, R_DROP};
   wire ack_push = pkt_end && proto && pkt_ok && auto_ack && !ack_full;
   wire ack_pop  = st_tx == T_ACK && tx_free;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ack_wp <= '0;
         ack_rp <= '0;
         ack_n  <= '0;
      end else if (ce) begin
         if (ack_push) ack_wp <= ack_wp + 1'b1;
         if (ack_pop) ack_rp <= ack_rp + 1'b1;
         ack_n <= ack_n + (AW+1)'(ack_push) - (AW+1)'(ack_pop);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (ce && ack_push) ack_mem[ack_wp] <= hdr[2];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit: memory data, optional checksum, then the configured EOP marker.
   // Outgoing headers are built by the host and pass through unread.
   logic [7:0] tx_csum;
   wire take = mem_valid && mem_ready;
   wire [TOK_W-1:0] eop_tok = {1'b1, cfg_mode[M_EOP2] ? CTL_EOP2 : CTL_EOP1};

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_tx        <= T_IDLE;
         tx_tok_valid <= 1'b0;
         tx_tok       <= '0;
         tx_csum      <= 8'h00;
         mem_ready    <= 1'b0;
      end else if (ce) begin
         mem_ready <= st_tx == T_DATA && !take && tx_free;
         if (tx_tok_ready) tx_tok_valid <= 1'b0;
         unique case (st_tx)
            T_IDLE: begin
               if (ack_n != '0) st_tx <= T_ACK;
               else if (mem_valid) st_tx <= T_DATA;
            end
            T_DATA: if (take) begin
               tx_tok       <= {1'b0, mem_data};
               tx_tok_valid <= 1'b1;
               tx_csum      <= tx_csum ^ mem_data;
               if (mem_last) st_tx <= chk_en ? T_CHK : T_EOP;
            end
            T_CHK: if (tx_free) begin
               tx_tok       <= {1'b0, tx_csum};
               tx_tok_valid <= 1'b1;
               st_tx        <= T_EOP;
            end
            T_EOP: if (tx_free) begin
               tx_tok       <= eop_tok;
               tx_tok_valid <= 1'b1;
               tx_csum      <= 8'h00;
               st_tx        <= T_IDLE;
            end
            T_ACK: if (tx_free) begin
               tx_tok       <= {1'b0, ack_mem[ack_rp]};
               tx_tok_valid <= 1'b1;
               st_tx        <= T_ACKE;
            end
            T_ACKE: if (tx_free) begin
               tx_tok       <= eop_tok;
               tx_tok_valid <= 1'b1;
               st_tx        <= T_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read with byte-lane mapping; upper bytes are zero when unused.
   wire [7:0] rd_b0 =
      (reg_addr == A_MODE)   ? cfg_mode :
      (reg_addr == A_CHADDR) ? ch_addr :
      (reg_addr == A_RTSELF) ? rt_self :
      (wr_rtl || (reg_addr >= A_RTL0 && reg_addr <= A_RTL2)) ? rt_link[rtl_idx] :
      (reg_addr == A_STAT)   ? {4'h0, sc_en, stat} :
      (reg_addr == A_MASK)   ? mask :
      (reg_addr == A_CMD)    ? {3'h0, cmd_lines} :
      (reg_addr == A_HDRCMD) ? cmd :
      (reg_addr == A_CNTLO)  ? pkt_cnt[7:0] :
      (reg_addr == A_CNTHI)  ? pkt_cnt[15:8] : 8'h00;
   wire [7:0] rd_b1 = (reg_addr == A_CNTLO && wid != WID_8) ? pkt_cnt[15:8] : 8'h00;
   wire [31:0] rd_word = big_end ? {rd_b0, rd_b1, 16'h0000}
                                 : {16'h0000, rd_b1, rd_b0};

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) reg_rdata <= 32'h0000_0000;
      else if (ce) reg_rdata <= reg_re ? rd_word : 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst || !ce);

   a_reset_mode_transp: assert property ($past(rst) |-> mode == MODE_TRANSP)
      else $error("Channel not transparent after reset.");
   a_transp_no_ack: assert property (!proto |=> ack_n <= $past(ack_n))
      else $error("Acknowledge queued outside protocol mode.");
   a_eop_after_last: assert property (take && mem_last |=> st_tx inside {T_CHK, T_EOP})
      else $error("Last memory byte not followed by checksum or EOP.");
   a_hdr_four_bytes: assert property (hdr_last |=> st_rx != R_HDR && hdr_cnt == 2'h3)
      else $error("Header did not end after four bytes.");
   a_route_strip: assert property (route_1st |=> !rx_valid && !fwd_valid)
      else $error("Routing destination byte was delivered.");
   a_route_err_flag: assert property (route_err |=> stat[ST_RTERR])
      else $error("Unmatched destination did not set error.");
   a_proto_gate: assert property (proto && rx_valid && !rx_eop |-> pkt_ok)
      else $error("Protocol data delivered without accepted header.");
   a_no_exec_other: assert property (!proto |=> !link_reset && !all_reset)
      else $error("Command executed outside protocol mode.");
   a_sc_clear: assert property (exec_go && cmd_sc |=> !sc_en)
      else $error("Safety enable not cleared after safety command.");
   a_ack_waits: assert property (st_tx == T_IDLE && ack_n != '0 |=> st_tx == T_ACK)
      else $error("Queued acknowledge not started on an idle transmit path.");
   a_big_end_lane: assert property (big_end && $past(reg_re) |-> reg_rdata[15:0] == 16'h0000)
      else $error("Big endian read used low lanes.");
endmodule : lpu_channel

// ### lpu_link_model.sv
// Remote link node: sends one token per slow link clock, accepts tx tokens.
// Assumes the bench calls send once for each token.
`timescale 1ns/1ps
module lpu_link_model (
   input  wire logic  clk_sys,
   output logic       lnk_clk,
   output logic [8:0] lnk_tok,
   output logic       tx_tok_ready
);
   logic [2:0] st_cnt = 3'h0;
   initial begin
      lnk_clk = 1'b0;
      lnk_tok = 9'h0;
      tx_tok_ready = 1'b0;
   end
   // Stalls two cycles in eight, so both quick and slow acceptance occur.
   always @(posedge clk_sys) begin
      st_cnt <= st_cnt + 3'h1;
      tx_tok_ready <= (st_cnt[2:1] != 2'h3);
   end
   // The clock stands still between tokens and the token lines hold the last token.
   task automatic send(input logic [8:0] t);
      lnk_tok <= t;
      #160 lnk_clk <= 1'b1;
      #160 lnk_clk <= 1'b0;
   endtask : send
endmodule : lpu_link_model

// ### lpu_pin_sync.sv
// Three-stage synchroniser for pins from outside the system clock domain.
// A change is accepted only once the second and third stages agree.
`timescale 1ns/1ps
module lpu_pin_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] pin_lvl
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   wire  [W-1:0] agree = ~(s2 ^ s3);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s1      <= '0;
         s2      <= '0;
         s3      <= '0;
         pin_lvl <= '0;
      end else if (ce) begin
         s1      <= pin_in;
         s2      <= s1;
         s3      <= s2;
         pin_lvl <= (agree & s3) | (~agree & pin_lvl);
      end
   end
endmodule : lpu_pin_sync

// ### lpu_pkg.sv
// Constants shared by the link protocol processing unit: register offsets,
// field positions, reset values, token codes and command codes.
// Assumes a byte-wide register space reached over a plain strobe port.
package lpu_pkg;
   localparam int TOK_W    = 9;
   localparam int TOK_CTL  = 8;
   localparam int CMD_LINES = 5;
   localparam int HDR_LEN  = 4;
   localparam int NUM_LINKS = 3;

   localparam logic [7:0] A_MODE   = 8'h00;
   localparam logic [7:0] A_CHADDR = 8'h01;
   localparam logic [7:0] A_RTSELF = 8'h02;
   localparam logic [7:0] A_RTL0   = 8'h03;
   localparam logic [7:0] A_RTL2   = 8'h05;
   localparam logic [7:0] A_STAT   = 8'h06;
   localparam logic [7:0] A_MASK   = 8'h07;
   localparam logic [7:0] A_CMD    = 8'h08;
   localparam logic [7:0] A_HDRCMD = 8'h09;
   localparam logic [7:0] A_CNTLO  = 8'h0a;
   localparam logic [7:0] A_CNTHI  = 8'h0b;

   localparam int M_MODE_LSB = 0;
   localparam int M_AUTOACK  = 2;
   localparam int M_CHK      = 3;
   localparam int M_EOP2     = 4;
   localparam int M_WID_LSB  = 5;

   localparam logic [1:0] MODE_TRANSP = 2'h0;
   localparam logic [1:0] MODE_ROUTE  = 2'h1;
   localparam logic [1:0] MODE_PROTO  = 2'h2;
   localparam logic [1:0] WID_8       = 2'h0;

   localparam int ST_RTERR = 0;
   localparam int ST_HDERR = 1;
   localparam int ST_CKERR = 2;
   localparam int ST_SCEN  = 3;

   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] ADDR_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;

   localparam logic [7:0] CTL_EOP1 = 8'h00;
   localparam logic [7:0] CTL_EOP2 = 8'h01;

   localparam logic [7:0] CMD_DATA        = 8'h01;
   localparam logic [7:0] CMD_CPU_RST_ON  = 8'h10;
   localparam logic [7:0] CMD_CPU_RST_OFF = 8'h11;
   localparam logic [7:0] CMD_SIG_SET     = 8'h12;
   localparam logic [7:0] CMD_SIG_CLR     = 8'h13;
   localparam logic [7:0] CMD_LINK_RST    = 8'h14;
   localparam logic [7:0] CMD_ALL_RST     = 8'h15;
   localparam logic [7:0] CMD_SC_ENABLE   = 8'h16;
endpackage : lpu_pkg

// ### testbench.sv
// Bench for one link channel: register port, link receive and transmit.
// Assumes the partner in lpu_link_model.sv.
`timescale 1ns/1ps
module testbench;
   import lpu_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, strap = 1'b0, ign = 1'b0;
   logic we = 1'b0, re = 1'b0, mv = 1'b0, ml = 1'b0, lw = 1'b0;
   logic [7:0] ra = 8'h0, md = 8'h0, sd = 8'h45, v, rxd, fwd, lwd = 8'h0;
   logic [7:0] cl[3] = '{CMD_LINK_RST, CMD_SC_ENABLE, CMD_ALL_RST};
   logic [31:0] wd = 32'h0, rdat;
   logic lclk, rdy, rxv, rxe, fwv, fwe, mr, txv, lr, ar, irq;
   logic [8:0] ltok, txt, q_rx[$], q_tx[$];
   logic [10:0] q_fw[$];
   logic [1:0] fwl;
   logic [4:0] cmdl;
   int err_count = 0, samples_checked = 0, cyc = 0, nlr = 0, nar = 0;
   always #20 clk_sys = ~clk_sys;
   lpu_channel u_dut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .reg_addr(ra),
      .reg_wdata(wd), .reg_we(we), .reg_re(re), .reg_rdata(rdat),
      .host_byte_order_strap(strap), .cfg_link_we(lw), .cfg_link_wdata(lwd),
      .lnk_clk(lclk), .lnk_tok(ltok), .rx_valid(rxv), .rx_data(rxd), .rx_eop(rxe),
      .fwd_valid(fwv), .fwd_link(fwl), .fwd_data(fwd), .fwd_eop(fwe),
      .mem_valid(mv), .mem_data(md), .mem_last(ml), .mem_ready(mr),
      .tx_tok_valid(txv), .tx_tok(txt), .tx_tok_ready(rdy), .cmd_lines(cmdl),
      .link_reset(lr), .all_reset(ar), .err_irq(irq));
   lpu_link_model u_link (.clk_sys(clk_sys), .lnk_clk(lclk), .lnk_tok(ltok),
      .tx_tok_ready(rdy));
   function automatic logic [7:0] nx(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : nx
   function automatic logic [31:0] ln(input logic [7:0] x);
      return strap ? {x, 24'h0} : {24'h0, x};
   endfunction : ln
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      samples_checked++;
      if (s !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, s);
         err_count++;
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      we <= 1'b1;
      ra <= a;
      wd <= ln(d);
      @(posedge clk_sys);
      we <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      re <= 1'b1;
      ra <= a;
      @(posedge clk_sys);
      re <= 1'b0;
      #1 chk("reg_rdata", e, rdat);
   endtask : rd
   task automatic put(input logic [7:0] d, input logic l);
      @(posedge clk_sys);
      mv <= 1'b1;
      md <= d;
      ml <= l;
      do @(posedge clk_sys); while (!mr);
      mv <= 1'b0;
   endtask : put
   task automatic pk(input logic [7:0] a, c, t, g);
      u_link.send({1'b0, a});
      u_link.send({1'b0, c});
      u_link.send({1'b0, t});
      u_link.send({1'b0, g});
   endtask : pk
   task automatic settle();
      for (int i = 0; i < 400 && (q_rx.size() + q_tx.size() + q_fw.size()) > 0; i++)
         @(posedge clk_sys);
      repeat (20) @(posedge clk_sys);
   endtask : settle
   task automatic give_verdict();
      if (q_rx.size() + q_tx.size() + q_fw.size() > 0)
         err_count++;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict
   // Outputs are sampled at the edge, before that edge's updates land.
   always @(posedge clk_sys) begin
      cyc++;
      if (lr === 1'b1) nlr++;
      if (ar === 1'b1) nar++;
      if (rxv === 1'b1 && !ign)
         chk("rx", q_rx.size() ? q_rx.pop_front() : 9'h1ff, {rxe, rxd});
      if (fwv === 1'b1)
         chk("fwd", q_fw.size() ? q_fw.pop_front() : 11'h7ff, {fwe, fwl, fwd});
      if (txv === 1'b1 && rdy)
         chk("tx", q_tx.size() ? q_tx.pop_front() : 9'h1ff, txt);
      if (cyc == 20000) begin
         err_count++;
         give_verdict();
      end
   end
   initial begin
      for (int s = 0; s < 2; s++) begin
         strap <= s[0];
         rst <= 1'b1;
         repeat (4) @(posedge clk_sys);
         rst <= 1'b0;
         repeat (6) @(posedge clk_sys);
         sd = nx(sd);
         v = sd;
         rd(A_MODE, ln(MODE_RST));
         rd(8'h3f, 32'h0);
         wr(A_CHADDR, v);
         rd(A_CHADDR, ln(v));
         wr(A_MODE, 8'h40);
         rd(A_CHADDR, ln(v));
      end
      wr(A_MODE, 8'h10);
      for (int i = 0; i < 3; i++) begin
         sd = nx(sd);
         q_rx.push_back({1'b0, sd});
         u_link.send({1'b0, sd});
      end
      q_rx.push_back(9'h100);
      u_link.send({1'b1, CTL_EOP2});
      q_tx = '{{1'b0, v}, {1'b0, ~v}, {1'b1, CTL_EOP2}};
      put(v, 1'b0);
      put(~v, 1'b1);
      settle();
      wr(A_RTSELF, 8'h21);
      wr(A_RTL0 + 8'h1, 8'h42);
      wr(A_MODE, {6'h0, MODE_ROUTE});
      q_rx = '{{1'b0, v}, 9'h100, {1'b0, ~v}, 9'h100};
      q_fw = '{{1'b0, 2'h1, v}, {1'b1, 2'h1, 8'h0}};
      for (int i = 0; i < 3; i++) begin
         u_link.send({1'b0, i == 0 ? 8'h21 : i == 1 ? 8'h42 : 8'h77});
         u_link.send({1'b0, i == 2 ? ~v : v});
         u_link.send({1'b1, CTL_EOP1});
      end
      settle();
      rd(A_STAT, ln(8'h01));
      wr(A_MASK, 8'h01);
      repeat (3) @(posedge clk_sys);
      chk("err_irq", 32'h1, irq);
      lwd <= 8'h06;
      lw  <= 1'b1;
      @(posedge clk_sys) lw <= 1'b0;
      sd = nx(sd);
      q_rx = '{{1'b0, sd}, 9'h100};
      q_tx = '{{1'b0, 8'h3c}, {1'b1, CTL_EOP1}, {1'b0, 8'hc3}, {1'b1, CTL_EOP1}};
      pk(v, CMD_DATA, 8'h3c, 8'h00);
      u_link.send({1'b0, sd});
      u_link.send({1'b1, CTL_EOP1});
      settle();
      ign = 1'b1;
      pk(v, CMD_SIG_SET, 8'hc3, 8'h05);
      u_link.send({1'b1, CTL_EOP1});
      settle();
      chk("cmd_lines", 32'h0a, cmdl);
      rd(A_HDRCMD, ln(CMD_SIG_SET));
      foreach (cl[i]) begin
         q_tx.push_back({1'b0, cl[i]});
         q_tx.push_back(9'h100);
         pk(v, cl[i], cl[i], 8'h00);
         u_link.send(9'h100);
      end
      settle();
      chk("link_reset", 32'h1, nlr);
      chk("all_reset", 32'h1, nar);
      rd(A_STAT, ln(8'h01));
      for (int i = 0; i < 4; i++) begin
         q_tx.push_back({1'b0, v ^ 8'(i)});
         put(v ^ 8'(i), i == 3);
      end
      q_tx.push_back(9'h100);
      settle();
      give_verdict();
   end
endmodule : testbench
